// ===== pkg/tws_regs.svh
// register offsets, field positions, reset values and timing counts of the two-wire controller
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// ==========================================================
// register offsets
`define TWS_OFS_CFG 8'h09
`define TWS_OFS_SC 8'h28
`define TWS_OFS_DATA 8'h29

// ==========================================================
// status/control field positions
`define TWS_SC_EN 0
`define TWS_SC_STOP 1
`define TWS_SC_LOST 2
`define TWS_SC_ADDR 3
`define TWS_SC_ACK 4
`define TWS_SC_XMIT 5
`define TWS_SC_CONT 6
`define TWS_SC_ROLE 7

// ==========================================================
// configuration field positions
`define TWS_CFG_POS 7
`define TWS_CFG_W1 1

// ==========================================================
// reset values
`define TWS_SC_RST 8'h00
`define TWS_CFG_RST 8'h00

// ==========================================================
// timing: 100 kHz bit time, 20 MHz clock, four phases per bit
`define TWS_BIT_NS 10000
`define TWS_CLK_NS 50
`define TWS_QTR_CYC ((`TWS_BIT_NS / 4) / `TWS_CLK_NS)
`define TWS_BYTE_BITS 4'h8

`endif

// ===== pkg/tws_pkg.sv
// types shared by the two-wire controller modules
`default_nettype none
package tws_pkg;

  // ========================================================
  // controller states, one-hot
  typedef enum logic [10:0] {
    ST_IDLE    = 11'h001,
    ST_MSTART  = 11'h002,
    ST_MBIT    = 11'h004,
    ST_MACK    = 11'h008,
    ST_HOLD    = 11'h010,
    ST_MRSTART = 11'h020,
    ST_MSTOP   = 11'h040,
    ST_SRX     = 11'h080,
    ST_SACK    = 11'h100,
    ST_STX     = 11'h200,
    ST_LOST    = 11'h400
  } tws_state_type;

endpackage : tws_pkg

`default_nettype wire

// ===== pkg/tws_line_if.sv
// synchronised line levels and line events passed from the sampler to the controller
`timescale 1ns/10ps
`default_nettype none

interface tws_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic qtick;

  // ========================================================
  // sampler drives, controller listens
  modport engine(output scl, sda, scl_rise, scl_fall, start_det, stop_det, qtick);
  modport ctrl(input scl, sda, scl_rise, scl_fall, start_det, stop_det, qtick);
endinterface : tws_line_if

`default_nettype wire

// ===== core/tws_line_sync.sv
// line sampler: pin synchronisers, edge and start/stop detection, quarter-bit tick
`timescale 1ns/10ps
`default_nettype none
`include "tws_regs.svh"

module tws_line_sync #(
  parameter int QTR_CYC = `TWS_QTR_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // raw pin levels
  input wire logic scl_pin_i,
  input wire logic sda_pin_i,
  // line events
  tws_line_if.engine ln
);

  // ========================================================
  // parameter check
  generate
    if (QTR_CYC < 2 || QTR_CYC > 255) begin : g_bad_qtr
      $error("tws_line_sync: QTR_CYC must lie in 2..255");
    end
  endgenerate

  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic scl_prev;
  logic sda_prev;
  logic [7:0] div;
  logic [7:0] div_last;

  assign div_last = 8'(QTR_CYC - 1);

  // ========================================================
  // two-flop sync
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= {scl_meta[0], scl_pin_i};
      sda_meta <= {sda_meta[0], sda_pin_i};
      scl_prev <= scl_meta[1];
      sda_prev <= sda_meta[1];
    end
  end

  assign ln.scl = scl_meta[1];
  assign ln.sda = sda_meta[1];
  assign ln.scl_rise = scl_meta[1] & ~scl_prev;
  assign ln.scl_fall = ~scl_meta[1] & scl_prev;
  // data falling while clock high is a start, rising is a stop
  assign ln.start_det = scl_meta[1] & scl_prev & sda_prev & ~sda_meta[1];
  assign ln.stop_det = scl_meta[1] & scl_prev & ~sda_prev & sda_meta[1];

  // ========================================================
  // free-running quarter-bit divider; the master aligns to it
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div <= 8'h00;
    end else if (div == div_last) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end

  assign ln.qtick = (div == div_last);

endmodule : tws_line_sync

`default_nettype wire

// ===== core/tws_ctrl.sv
// two-wire master/slave byte controller with register port and gpio pin takeover
// Summary of operation
// - enable takes pins from gpio
// - enabled pins are open drain only
// - role set sends start then data byte
// - role cleared one to zero sends stop
// - master clocks, drives data, arbitrates, synchronises
// - lost arbitration clears role, flags, interrupts
// - lost arbitration mid-byte interrupt waits for bus end; role set on a busy bus interrupts at once
// - busy reads one and locks status writes
// - after interrupt wait for continue write
// - direction bit: one transmit, zero receive
// - first byte after start always transmits
// - receive acknowledge from acknowledge bit
// - transmit acknowledge bit shows receiver answer
// - first-byte flag set, cleared by continue
// - repeat start with continue and role
// - hardware clears repeat-start bit itself
// - slave receive stop flag unless nacked
// - interrupt per byte, stop, lost arbitration
// - hold clock low while firmware responds
// - clock bit0, data bit1, port 1/2
// - separate receive and transmit data registers
`timescale 1ns/10ps
`default_nettype none
`include "tws_regs.svh"

module tws_ctrl #(
  parameter int QTR_CYC = `TWS_QTR_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // interrupt request, one cycle per event
  output logic irq_o,
  // gpio port 1 low pins: gpio logic request and pin levels
  input wire logic [1:0] gp1_do_i,
  input wire logic [1:0] gp1_oe_b_i,
  input wire logic [1:0] p1_in_i,
  output logic [1:0] p1_out_o,
  output logic [1:0] p1_oe_b_o,
  // gpio port 2 low pins
  input wire logic [1:0] gp2_do_i,
  input wire logic [1:0] gp2_oe_b_i,
  input wire logic [1:0] p2_in_i,
  output logic [1:0] p2_out_o,
  output logic [1:0] p2_oe_b_o
);

  // ========================================================
  // declarations
  tws_pkg::tws_state_type state;
  logic enable, role, xmit, ack, addr_flag, lost, restart, stop_seen;
  logic cfg_pos;
  logic [1:0] cfg_width;
  logic [7:0] tx_data, rx_data, shift;
  logic [3:0] cnt;
  logic [1:0] phase;
  logic scl_low, sda_low, nacked, was_rx, byte_tx, bus_act;
  logic use_p2, use_p1, busy, wr_sc, wr_ok, go, role_set, role_clr, slave_st, tick;
  logic [7:0] sc_view, cfg_view, rd_mux;

  tws_line_if ln();

  assign use_p2 = cfg_pos | cfg_width[`TWS_CFG_W1];
  assign use_p1 = enable & ~use_p2;

  tws_line_sync #(.QTR_CYC(QTR_CYC)) u_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .scl_pin_i(use_p2 ? p2_in_i[0] : p1_in_i[0]),
    .sda_pin_i(use_p2 ? p2_in_i[1] : p1_in_i[1]),
    .ln(ln)
  );

  // ========================================================
  // pin takeover
  // gpio when disabled
  // open drain: output level low, enable only to pull
  assign p1_out_o = use_p1 ? 2'h0 : gp1_do_i;
  assign p1_oe_b_o = use_p1 ? {~sda_low, ~scl_low} : gp1_oe_b_i;
  assign p2_out_o = (enable & use_p2) ? 2'h0 : gp2_do_i;
  assign p2_oe_b_o = (enable & use_p2) ? {~sda_low, ~scl_low} : gp2_oe_b_i;

  // ========================================================
  // write decode
  // busy locks status writes
  assign busy = (state != tws_pkg::ST_IDLE) && (state != tws_pkg::ST_HOLD);
  assign wr_sc = wr_i && (addr_i == `TWS_OFS_SC);
  assign wr_ok = wr_sc & ~busy;
  assign go = wr_ok & wdata_i[`TWS_SC_CONT];
  assign role_set = wr_ok & wdata_i[`TWS_SC_ROLE] & ~role & enable;
  assign role_clr = wr_ok & ~wdata_i[`TWS_SC_ROLE] & role;
  assign slave_st = (state == tws_pkg::ST_SRX) || (state == tws_pkg::ST_SACK) ||
                    (state == tws_pkg::ST_STX) || ((state == tws_pkg::ST_HOLD) && !role);
  assign tick = ln.qtick;

  // ========================================================
  // read view
  // bit 2 shares lost and pending repeat start; hardware clears the latter
  assign sc_view = {role, busy, xmit, ack, addr_flag, lost | restart, stop_seen, enable};
  assign cfg_view = {cfg_pos, 5'h00, cfg_width};
  assign rd_mux = (addr_i == `TWS_OFS_SC) ? sc_view :
                  (addr_i == `TWS_OFS_DATA) ? rx_data :
                  (addr_i == `TWS_OFS_CFG) ? cfg_view : 8'h00;

  // read data valid the cycle after the strobe; config and transmit data writes
  // transmit byte kept apart from received byte
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
      tx_data <= 8'h00;
      {cfg_pos, cfg_width} <= 3'h0;
    end else begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
      if (wr_i && addr_i == `TWS_OFS_DATA) begin
        tx_data <= wdata_i;
      end
      if (wr_i && addr_i == `TWS_OFS_CFG) begin
        {cfg_pos, cfg_width} <= {wdata_i[`TWS_CFG_POS], wdata_i[1:0]};
      end
    end
  end

  // bus occupancy seen from start and stop conditions
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_act <= 1'b0;
    end else if (ln.start_det) begin
      bus_act <= 1'b1;
    end else if (ln.stop_det || !enable) begin
      bus_act <= 1'b0;
    end
  end

  // ========================================================
  // status bits and byte sequencer; hardware sets follow the firmware write so they win
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {role, xmit, ack, addr_flag, lost, stop_seen, enable} <= 7'h00;
      restart <= 1'b0;
      state <= tws_pkg::ST_IDLE;
      {scl_low, sda_low, nacked, was_rx, byte_tx} <= 5'h00;
      shift <= 8'h00;
      rx_data <= 8'h00;
      cnt <= 4'h0;
      phase <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      irq_o <= 1'b0;
      if (wr_ok) begin
        enable <= wdata_i[`TWS_SC_EN];
        role <= wdata_i[`TWS_SC_ROLE];
        xmit <= wdata_i[`TWS_SC_XMIT];
        ack <= wdata_i[`TWS_SC_ACK];
        restart <= wdata_i[`TWS_SC_LOST];
        lost <= 1'b0;
        stop_seen <= stop_seen & wdata_i[`TWS_SC_STOP];
        if (wdata_i[`TWS_SC_CONT]) begin
          addr_flag <= 1'b0;
        end
      end
      if (!enable) begin
        // disabled controller lets go of both lines
        state <= tws_pkg::ST_IDLE;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
      end else begin
        case (state)
          tws_pkg::ST_IDLE: begin
            if (role_set && bus_act) begin
              // bus already taken by someone else: report as lost
              role <= 1'b0;
              lost <= 1'b1;
              addr_flag <= 1'b1;
              irq_o <= 1'b1;
            end else if (role_set) begin
              // start then first byte; always transmit
              shift <= tx_data;
              byte_tx <= 1'b1;
              phase <= 2'h0;
              state <= tws_pkg::ST_MSTART;
            end
          end
          tws_pkg::ST_MSTART: begin
            if (tick) begin
              phase <= phase + 2'h1;
              if (phase == 2'h0) begin
                sda_low <= 1'b1;
              end else begin
                scl_low <= 1'b1;
                phase <= 2'h0;
                cnt <= `TWS_BYTE_BITS;
                state <= tws_pkg::ST_MBIT;
              end
            end
          end
          tws_pkg::ST_MBIT: begin
            // master clocks and drives the data bits
            if (tick) begin
              case (phase)
                2'h0: begin
                  sda_low <= byte_tx & ~shift[7];
                  phase <= 2'h1;
                end
                2'h1: begin
                  scl_low <= 1'b0;
                  phase <= 2'h2;
                end
                2'h2: begin
                  // clock sync: wait while another device holds clock low
                  if (ln.scl) begin
                    shift <= {shift[6:0], ln.sda};
                    cnt <= cnt - 4'h1;
                    phase <= 2'h3;
                    // released a one but line reads zero
                    if (byte_tx && shift[7] && !ln.sda) begin
                      role <= 1'b0;
                      lost <= 1'b1;
                      addr_flag <= 1'b1;
                      sda_low <= 1'b0;
                      state <= tws_pkg::ST_LOST;
                    end
                  end
                end
                default: begin
                  scl_low <= 1'b1;
                  phase <= 2'h0;
                  if (cnt == 4'h0) begin
                    state <= tws_pkg::ST_MACK;
                  end
                end
              endcase
            end
          end
          tws_pkg::ST_MACK: begin
            if (tick) begin
              phase <= phase + 2'h1;
              case (phase)
                // receiver pulls data low when the ack bit is one
                2'h0: sda_low <= ~byte_tx & ack;
                2'h1: scl_low <= 1'b0;
                2'h2: begin
                  if (!ln.scl) begin
                    phase <= 2'h2;
                  end else if (byte_tx) begin
                    ack <= ~ln.sda;
                  end
                end
                default: begin
                  scl_low <= 1'b1;
                  if (!byte_tx) begin
                    rx_data <= shift;
                  end
                  was_rx <= ~byte_tx;
                  irq_o <= 1'b1;
                  state <= tws_pkg::ST_HOLD;
                end
              endcase
            end
          end
          tws_pkg::ST_HOLD: begin
            // stays here until continue, or as master a role clear, is written
            if (role) begin
              if (role_clr) begin
                phase <= 2'h0;
                state <= tws_pkg::ST_MSTOP;
              end else if (go) begin
                phase <= 2'h0;
                cnt <= `TWS_BYTE_BITS;
                if (wdata_i[`TWS_SC_LOST]) begin
                  state <= tws_pkg::ST_MRSTART;
                end else begin
                  // direction bit picks this byte's direction
                  shift <= tx_data;
                  byte_tx <= wdata_i[`TWS_SC_XMIT];
                  state <= tws_pkg::ST_MBIT;
                end
              end
            end else if (go) begin
              scl_low <= 1'b0;
              cnt <= `TWS_BYTE_BITS;
              if (was_rx) begin
                sda_low <= wdata_i[`TWS_SC_ACK];
                nacked <= ~wdata_i[`TWS_SC_ACK];
                state <= tws_pkg::ST_SACK;
              end else if (nacked) begin
                state <= tws_pkg::ST_SRX;
              end else begin
                shift <= tx_data;
                sda_low <= ~tx_data[7];
                state <= tws_pkg::ST_STX;
              end
            end
          end
          tws_pkg::ST_MRSTART: begin
            if (tick) begin
              phase <= phase + 2'h1;
              case (phase)
                2'h0: sda_low <= 1'b0;
                2'h1: scl_low <= 1'b0;
                2'h2: begin
                  if (!ln.scl) begin
                    phase <= 2'h2;
                  end else begin
                    sda_low <= 1'b1;
                    restart <= 1'b0;
                  end
                end
                default: begin
                  scl_low <= 1'b1;
                  shift <= tx_data;
                  byte_tx <= 1'b1;
                  state <= tws_pkg::ST_MBIT;
                end
              endcase
            end
          end
          tws_pkg::ST_MSTOP: begin
            if (tick) begin
              phase <= phase + 2'h1;
              case (phase)
                2'h0: sda_low <= 1'b1;
                2'h1: scl_low <= 1'b0;
                default: begin
                  if (!ln.scl) begin
                    phase <= phase;
                  end else begin
                    sda_low <= 1'b0;
                    state <= tws_pkg::ST_IDLE;
                  end
                end
              endcase
            end
          end
          tws_pkg::ST_SRX: begin
            if (ln.scl_rise && cnt != 4'h0) begin
              shift <= {shift[6:0], ln.sda};
              cnt <= cnt - 4'h1;
            end
            if (ln.scl_fall && cnt == 4'h0) begin
              // stretch clock while firmware reads the byte
              scl_low <= 1'b1;
              rx_data <= shift;
              was_rx <= 1'b1;
              irq_o <= 1'b1;
              state <= tws_pkg::ST_HOLD;
            end
          end
          tws_pkg::ST_SACK: begin
            if (was_rx && ln.scl_fall) begin
              cnt <= `TWS_BYTE_BITS;
              sda_low <= xmit & ~tx_data[7];
              shift <= tx_data;
              // slave direction from the direction bit
              state <= xmit ? tws_pkg::ST_STX : tws_pkg::ST_SRX;
            end else if (!was_rx && ln.scl_rise) begin
              ack <= ~ln.sda;
              nacked <= ln.sda;
            end else if (!was_rx && ln.scl_fall) begin
              scl_low <= 1'b1;
              irq_o <= 1'b1;
              state <= tws_pkg::ST_HOLD;
            end
          end
          tws_pkg::ST_STX: begin
            if (ln.scl_rise) begin
              cnt <= cnt - 4'h1;
            end
            if (ln.scl_fall && cnt == 4'h0) begin
              sda_low <= 1'b0;
              was_rx <= 1'b0;
              state <= tws_pkg::ST_SACK;
            end else if (ln.scl_fall) begin
              shift <= {shift[6:0], 1'b0};
              sda_low <= ~shift[6];
            end
          end
          tws_pkg::ST_LOST: begin
            // interrupt withheld until the winner's stop
            if (ln.stop_det) begin
              irq_o <= 1'b1;
              state <= tws_pkg::ST_IDLE;
            end
          end
          default: state <= tws_pkg::ST_IDLE;
        endcase
        // slave side: start and stop override any slave step
        if ((slave_st || state == tws_pkg::ST_IDLE) && !role && ln.start_det) begin
          // first byte after start or restart
          addr_flag <= 1'b1;
          cnt <= `TWS_BYTE_BITS;
          nacked <= 1'b0;
          scl_low <= 1'b0;
          sda_low <= 1'b0;
          state <= tws_pkg::ST_SRX;
        end else if (slave_st && ln.stop_det) begin
          // stop flagged only for an acknowledged receive
          if (!xmit && !nacked) begin
            stop_seen <= 1'b1;
            irq_o <= 1'b1;
          end
          scl_low <= 1'b0;
          sda_low <= 1'b0;
          state <= tws_pkg::ST_IDLE;
        end
      end
    end
  end

endmodule : tws_ctrl

`default_nettype wire

// ===== tb/tws_ctrl_props.sv
// port checker for the two-wire controller
`timescale 1ns/10ps
`default_nettype none
module tws_ctrl_props #(parameter int QTR_CYC = 4) (
  // clock, reset and register port
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  // port 1 pins
  input wire logic [1:0] gp1_do_i,
  input wire logic [1:0] gp1_oe_b_i,
  input wire logic [1:0] p1_in_i,
  input wire logic [1:0] p1_out_o,
  input wire logic [1:0] p1_oe_b_o
);
  localparam int SW = 8 * QTR_CYC + 8;
  logic en, role, wait_fw, rd_sc, rd_idle, sc_wr, take, p2sel;
  logic [1:0] pin_q;
  // writes land only while the controller is idle or waiting for firmware
  assign sc_wr = wr_i && addr_i == 8'h28;
  assign take = sc_wr && (wait_fw || !role);
  // shadow of enable and role; role is refused while the bus is busy
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {en, role, wait_fw, rd_sc, rd_idle, p2sel} <= 6'h00;
      pin_q <= 2'b11;
    end else begin
      if (take) en <= wdata_i[0];
      if (take) role <= wdata_i[7] && (role || p1_in_i == 2'b11);
      wait_fw <= irq_o || (wait_fw && !sc_wr);
      rd_sc <= rd_i && addr_i == 8'h28;
      rd_idle <= rd_i && addr_i == 8'h28 && wait_fw;
      // a stop on the pins ends any mastership the shadow believes in
      if (pin_q == 2'b01 && p1_in_i == 2'b11) role <= 1'b0;
      pin_q <= p1_in_i;
      if (wr_i && addr_i == 8'h09) p2sel <= wdata_i[7] | wdata_i[1];
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  AST_GPIO_PASS: assert property (!(en && !p2sel) |-> p1_out_o == gp1_do_i && p1_oe_b_o == gp1_oe_b_i)
    else $error("pins not under gpio control");
  AST_OPEN_DRAIN: assert property (en && !p2sel |-> p1_out_o == 2'b00)
    else $error("owned pin driven high");
  AST_START: assert property (sc_wr && !role && wdata_i[7] && p1_in_i == 2'b11
    |-> ##[1:SW] ($fell(p1_oe_b_o[1]) && p1_oe_b_o[0])) else $error("no start");
  AST_STOP: assert property (sc_wr && wait_fw && role && !wdata_i[7]
    |-> ##[1:SW] ($rose(p1_oe_b_o[1]) && p1_oe_b_o[0])) else $error("no stop");
  AST_IRQ_STROBE: assert property (irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");
  AST_STRETCH: assert property (irq_o && role |-> (!p1_oe_b_o[0]) [*2])
    else $error("clock not held after byte");
  AST_NOT_BUSY: assert property (rd_idle |-> !rdata_o[6])
    else $error("busy before continue");
  AST_LOST_FLAGS: assert property (rd_sc && rdata_o[2] |-> !rdata_o[7] && rdata_o[3])
    else $error("lost flags inconsistent");
  COV_BYTE: cover property (irq_o && role);
  COV_LOST: cover property (rd_sc && rdata_o[2]);
  COV_STOP: cover property (sc_wr && wait_fw && role && !wdata_i[7]);
endmodule : tws_ctrl_props
`default_nettype wire

// ===== tb/tws_slave_model.sv
// behavioural slave device on the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module tws_slave_model #(
  parameter logic [7:0] TX_BYTE = 8'h5a
) (
  // resolved wire levels
  input wire logic scl_i,
  input wire logic sda_i,
  // refuse acknowledge when high
  input wire logic nack_i,
  // pull data low
  output logic sda_low_o = 1'b0
);
  int n = 10;
  logic [7:0] sh = 8'h00;
  logic rd = 1'b0;
  logic first = 1'b0;
  logic mack = 1'b0;
  // start frames a new address byte, stop makes the model quiet
  always @(sda_i) begin
    if (scl_i) begin
      n = sda_i ? 10 : -1;
      first = !sda_i;
      rd = 1'b0;
    end
  end
  // sample on clock rise, msb first
  always @(posedge scl_i) begin
    if (n >= 0 && n < 8) sh = {sh[6:0], sda_i};
    if (n == 8) mack = !sda_i;
  end
  // data changes only while the clock is low; a master nack ends reading
  always @(negedge scl_i) begin
    if (n < 10) n = n + 1;
    if (n == 9) begin
      n = 0;
      rd = first ? sh[0] : rd;
      first = 1'b0;
    end
    sda_low_o = (n == 8) ? !nack_i && (first || !rd) : n < 8 && rd && mack && !TX_BYTE[7 - n];
  end
endmodule : tws_slave_model
`default_nettype wire

// ===== tb/tws_ctrl_test.sv
// register-level bench for the two-wire controller
`timescale 1ns/10ps
`default_nettype none
module tws_ctrl_test;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, irq_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [1:0] gp_do = 2'b10, gp_oe_b = 2'b01, p1_out_o, p1_oe_b_o, p1_in_i;
  logic nack = 1'b0, ext_low = 1'b0, ext_scl_low = 1'b0, sda_low, scl_w, sda_w;
  logic [3:0] p2_pins;
  logic [7:0] xb = 8'h6c;
  logic [8:0] mon = 9'h000;
  int num_errors = 0, n_compared = 0, stops = 0, i;
  // open-drain wires with pull-ups
  assign scl_w = (p1_oe_b_o[0] | p1_out_o[0]) & !ext_scl_low;
  assign sda_w = (p1_oe_b_o[1] | p1_out_o[1]) & !sda_low & !ext_low;
  assign p1_in_i = {sda_w, scl_w};
  initial forever #25 mclk_i = ~mclk_i;
  // wire monitor: bits at clock rise, stops
  always @(posedge scl_w) mon <= {mon[7:0], sda_w};
  always @(posedge sda_w) if (scl_w && rst_b_i) stops++;
  tws_ctrl #(.QTR_CYC(4)) u_tws_ctrl (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .gp1_do_i(gp_do), .gp1_oe_b_i(gp_oe_b), .p1_in_i(p1_in_i), .p1_out_o(p1_out_o),
    .p1_oe_b_o(p1_oe_b_o), .gp2_do_i(2'b11), .gp2_oe_b_i(2'b00), .p2_in_i(2'b11),
    .p2_out_o(p2_pins[3:2]), .p2_oe_b_o(p2_pins[1:0]));
  tws_slave_model u_tws_slave_model (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
    .sda_low_o(sda_low));
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk({1'b0, rdata_o}, {1'b0, e});
  endtask : rc
  task automatic wirq;
    for (i = 0; i < 900 && irq_o !== 1'b1; i++) @(negedge mclk_i);
    chk({8'h00, irq_o}, 9'h001);
  endtask : wirq
  // outside master bit: data set mid-low, 400 ns clock period
  task automatic xbit(input logic b);
    ext_low <= !b;
    repeat (2) @(posedge mclk_i);
    ext_scl_low <= 1'b0;
    repeat (4) @(posedge mclk_i);
    ext_scl_low <= 1'b1;
    repeat (2) @(posedge mclk_i);
  endtask : xbit
  // one continue write, then the byte on the wire and the status
  task automatic step(input logic [7:0] sc, input logic [8:0] m, input logic [7:0] st);
    wr(8'h28, sc);
    wirq();
    chk(mon, m);
    rc(8'h28, st);
  endtask : step
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  // watchdog well beyond the expected run of about a thousand cycles
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rc(8'h28, 8'h00);
    rc(8'h09, 8'h00);
    rc(8'h00, 8'h00);
    chk({7'h00, p1_out_o}, {7'h00, gp_do});
    wr(8'h28, 8'h01);
    #1 chk({1'b0, p1_out_o, p1_oe_b_o, p2_pins}, 9'h03c);
    wr(8'h09, 8'h80);
    #1 chk({1'b0, p1_out_o, p1_oe_b_o, p2_pins}, 9'h093);
    rc(8'h09, 8'h80);
    wr(8'h09, 8'h00);
    $display("test enable done");
    wr(8'h29, 8'ha4);
    wr(8'h28, 8'h81);
    repeat (10) @(posedge mclk_i);
    rc(8'h28, 8'hc1);
    wr(8'h28, 8'h00);
    wirq();
    chk(mon, {8'ha4, 1'b0});
    rc(8'h28, 8'h91);
    wr(8'h29, 8'h3c);
    nack <= 1'b1;
    step(8'he1, {8'h3c, 1'b1}, 8'ha1);
    nack <= 1'b0;
    wr(8'h29, 8'ha5);
    step(8'hc5, {8'ha5, 1'b0}, 8'h91);
    step(8'hd1, {8'h5a, 1'b0}, 8'h91);
    rc(8'h29, 8'h5a);
    step(8'hc1, {8'h5a, 1'b1}, 8'h81);
    wr(8'h28, 8'h01);
    for (i = 0; i < 200 && stops == 0; i++) @(negedge mclk_i);
    chk(stops[8:0], 9'h001);
    rc(8'h28, 8'h01);
    $display("test master done");
    wr(8'h28, 8'h81);
    // another master holds data low under our first one bit
    @(negedge scl_w);
    @(posedge mclk_i);
    ext_low <= 1'b1;
    repeat (12) @(posedge mclk_i);
    rc(8'h28, 8'h4d);
    ext_low <= 1'b0;
    wirq();
    rc(8'h28, 8'h0d);
    wr(8'h28, 8'h01);
    $display("test arbitration done");
    // outside master writes one byte to us, then stops
    nack <= 1'b1;
    ext_low <= 1'b1;
    repeat (4) @(posedge mclk_i);
    ext_scl_low <= 1'b1;
    repeat (2) @(posedge mclk_i);
    for (i = 7; i >= 0; i--) xbit(xb[i]);
    wirq();
    rc(8'h28, 8'h09);
    wr(8'h28, 8'h51);
    xbit(1'b1);
    chk(mon, {8'h6c, 1'b0});
    ext_low <= 1'b1;
    repeat (2) @(posedge mclk_i);
    ext_scl_low <= 1'b0;
    repeat (4) @(posedge mclk_i);
    ext_low <= 1'b0;
    wirq();
    rc(8'h28, 8'h13);
    rc(8'h29, 8'h6c);
    nack <= 1'b0;
    $display("test slave done");
    summarize();
  end
endmodule : tws_ctrl_test
bind tws_ctrl tws_ctrl_props #(.QTR_CYC(QTR_CYC)) u_tws_ctrl_props (.mclk_i(mclk_i),
  .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .gp1_do_i(gp1_do_i), .gp1_oe_b_i(gp1_oe_b_i),
  .p1_in_i(p1_in_i), .p1_out_o(p1_out_o), .p1_oe_b_o(p1_oe_b_o));
`default_nettype wire
